// File: shared/cobid_regs.vh
// Identifier layout, function codes, default identifiers and timing constants
`ifndef COBID_REGS_VH
`define COBID_REGS_VH
`define ID_W            11
`define FUNC_HI         10
`define FUNC_LO         7
`define NODE_HI         6
`define NODE_LO         0
`define FC_NMT          4'h0
`define FC_EMCY         4'h1
`define FC_TPDO1        4'h3
`define FC_RPDO1        4'h4
`define FC_TPDO2        4'h5
`define FC_RPDO2        4'h6
`define FC_TPDO3        4'h7
`define FC_RPDO3        4'h8
`define FC_TPDO4        4'h9
`define FC_RPDO4        4'ha
`define FC_SDO_TX       4'hb
`define FC_SDO_RX       4'hc
`define FC_GUARD        4'he
`define ID_SYNC         11'h080
`define ID_NMT          11'h000
`define OBJ_NONE        4'h0
`define OBJ_NMT         4'h1
`define OBJ_SYNC        4'h2
`define OBJ_EMCY        4'h3
`define OBJ_RPDO1       4'h4
`define OBJ_RPDO2       4'h5
`define OBJ_RPDO3       4'h6
`define OBJ_RPDO4       4'h7
`define OBJ_SDO_RX      4'h8
`define OBJ_GUARD       4'h9
`define TX_TPDO1        3'h0
`define TX_TPDO2        3'h1
`define TX_TPDO3        3'h2
`define TX_TPDO4        3'h3
`define TX_SDO          3'h4
`define TX_EMCY         3'h5
`define TX_GUARD        3'h6
`define CLK_HZ          50000000
`define HB_PERIOD_MS    1000
`define HB_LEN          4'h1
`endif

// File: hw/canopen_cobid_classifier.v
// Identifier classifier and frame builder for a CANopen slave node
// Operation
// - Multi-byte payload values are packed lowest byte first.
// - Identifiers are 11 bits, carried in the frame identifier field.
// - Top four identifier bits are function code, low seven the node address.
// - Network management and sync identifiers are common, independent of node address.
// - Emergency uses function code 0001 plus node address.
// - First transmit object 0011, first receive object 0100, with node address.
// - Second transmit object 0101, second receive object 0110, with node address.
// - Third transmit object 0111, third receive object 1000, with node address.
// - Fourth transmit object 1001, fourth receive object 1010, with node address.
// - Service responses use 1011, service requests use 1100, with node address.
// - Guarding and heartbeat use 1110 plus node address.
// - Default identifiers may be replaced by configured values.
// - The slave periodically transmits a message showing its connection is alive.
// - Only standard frames are accepted; extended frames are discarded.
`timescale 1ns/1ns
`include "cobid_regs.vh"
module canopen_cobid_classifier #(
	parameter HB_PERIOD_MS = `HB_PERIOD_MS,
	parameter HB_CYCLES    = (`CLK_HZ / 1000) * HB_PERIOD_MS
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        resetn,
	// Configuration from the object dictionary
	input  wire [6:0]  node_addr,
	input  wire        cfg_wr,
	input  wire [3:0]  cfg_sel,
	input  wire [10:0] cfg_id,
	input  wire        hb_enable,
	input  wire [7:0]  node_state,
	// Received frames from the data-link controller
	input  wire        rx_valid,
	input  wire        rx_ext,
	input  wire        rx_rtr,
	input  wire [10:0] rx_id,
	input  wire [3:0]  rx_len,
	input  wire [63:0] rx_data,
	// Classified frames to the application
	output reg         obj_valid,
	output reg  [3:0]  obj_type,
	output reg  [6:0]  obj_node,
	output reg         obj_rtr,
	output reg  [3:0]  obj_len,
	output reg  [63:0] obj_data,
	// Transmit requests from the application
	input  wire        app_tx_valid,
	output wire        app_tx_ready,
	input  wire [2:0]  app_tx_kind,
	input  wire [3:0]  app_tx_len,
	input  wire [31:0] app_tx_lo,
	input  wire [31:0] app_tx_hi,
	// Frames to the data-link controller
	output reg         tx_valid,
	input  wire        tx_ready,
	output reg  [10:0] tx_id,
	output reg  [3:0]  tx_len,
	output reg  [63:0] tx_data
);

	// Identifier table indices (receive objects then transmit objects)
	localparam [3:0] SEL_RPDO1 = 4'h0;
	localparam [3:0] SEL_RPDO2 = 4'h1;
	localparam [3:0] SEL_RPDO3 = 4'h2;
	localparam [3:0] SEL_RPDO4 = 4'h3;
	localparam [3:0] SEL_SDORX = 4'h4;
	localparam [3:0] SEL_TPDO1 = 4'h5;
	localparam [3:0] SEL_TPDO2 = 4'h6;
	localparam [3:0] SEL_TPDO3 = 4'h7;
	localparam [3:0] SEL_TPDO4 = 4'h8;
	localparam [3:0] SEL_SDOTX = 4'h9;
	localparam [3:0] SEL_EMCY  = 4'ha;
	localparam [3:0] SEL_GUARD = 4'hb;
	localparam [3:0] SEL_CNT   = 4'hc;
	localparam [31:0] HB_LAST  = HB_CYCLES - 1;

	reg  [10:0] id_tab_q [0:11];
	reg  [11:0] ovr_q;
	reg  [31:0] hb_cnt_q;
	reg         hb_pend_q;
	integer     i;

	// Default identifier: function code above node address
	function [10:0] mk_id;
		input [3:0] fc;
		input [6:0] na;
		begin
			mk_id = {fc, na};
		end
	endfunction

	// Default function code per table slot
	function [3:0] slot_fc;
		input [3:0] s;
		begin
			case (s)
				SEL_RPDO1: slot_fc = `FC_RPDO1;
				SEL_RPDO2: slot_fc = `FC_RPDO2;
				SEL_RPDO3: slot_fc = `FC_RPDO3;
				SEL_RPDO4: slot_fc = `FC_RPDO4;
				SEL_SDORX: slot_fc = `FC_SDO_RX;
				SEL_TPDO1: slot_fc = `FC_TPDO1;
				SEL_TPDO2: slot_fc = `FC_TPDO2;
				SEL_TPDO3: slot_fc = `FC_TPDO3;
				SEL_TPDO4: slot_fc = `FC_TPDO4;
				SEL_SDOTX: slot_fc = `FC_SDO_TX;
				SEL_EMCY:  slot_fc = `FC_EMCY;
				default:   slot_fc = `FC_GUARD;
			endcase
		end
	endfunction

	// Effective identifier: configured override or node-derived default
	function [10:0] eff_id;
		input [3:0] s;
		begin
			eff_id = ovr_q[s] ? id_tab_q[s] : mk_id(slot_fc(s), node_addr);
		end
	endfunction

	// Override table; a default follows node address changes until overridden
	always @(posedge core_clk) begin
		if (!resetn) begin
			ovr_q <= 12'h000;
			for (i = 0; i < 12; i = i + 1)
				id_tab_q[i] <= 11'h000;
		end else if (cfg_wr && cfg_sel < SEL_CNT) begin
			id_tab_q[cfg_sel] <= cfg_id;
			ovr_q[cfg_sel]    <= 1'b1;
		end
	end

	// Receive classification, one cycle latency
	reg [3:0] cls_d;
	always @* begin
		cls_d = `OBJ_NONE;
		if (rx_id == `ID_NMT)
			cls_d = `OBJ_NMT;
		else if (rx_id == `ID_SYNC)
			cls_d = `OBJ_SYNC;
		else if (rx_id == eff_id(SEL_RPDO1))
			cls_d = `OBJ_RPDO1;
		else if (rx_id == eff_id(SEL_RPDO2))
			cls_d = `OBJ_RPDO2;
		else if (rx_id == eff_id(SEL_RPDO3))
			cls_d = `OBJ_RPDO3;
		else if (rx_id == eff_id(SEL_RPDO4))
			cls_d = `OBJ_RPDO4;
		else if (rx_id == eff_id(SEL_SDORX))
			cls_d = `OBJ_SDO_RX;
		else if (rx_id == eff_id(SEL_GUARD))
			cls_d = `OBJ_GUARD; // guard request from master
		else if (rx_id[`FUNC_HI:`FUNC_LO] == `FC_EMCY && rx_id[`NODE_HI:`NODE_LO] != 7'h00)
			cls_d = `OBJ_EMCY; // Emergencies from any producer are consumable
	end

	always @(posedge core_clk) begin
		if (!resetn) begin
			obj_valid <= 1'b0;
			obj_type  <= `OBJ_NONE;
			obj_node  <= 7'h00;
			obj_rtr   <= 1'b0;
			obj_len   <= 4'h0;
			obj_data  <= 64'h0;
		end else begin
			obj_valid <= rx_valid && !rx_ext && cls_d != `OBJ_NONE;
			if (rx_valid && !rx_ext) begin
				obj_type <= cls_d;
				obj_node <= rx_id[`NODE_HI:`NODE_LO];
				obj_rtr  <= rx_rtr;
				obj_len  <= rx_len;
				obj_data <= rx_data;
			end
		end
	end

	// Heartbeat period divider
	always @(posedge core_clk) begin
		if (!resetn || !hb_enable) begin
			hb_cnt_q <= 32'h0;
		end else if (hb_cnt_q >= HB_LAST) begin
			hb_cnt_q <= 32'h0;
		end else begin
			hb_cnt_q <= hb_cnt_q + 32'h1;
		end
	end

	// Transmit side: a pending heartbeat has priority over application frames
	wire hb_tick  = hb_enable && hb_cnt_q >= HB_LAST;
	wire tx_free  = !tx_valid || tx_ready;
	wire hb_go    = tx_free && hb_pend_q;
	assign app_tx_ready = tx_free && !hb_pend_q;

	function [3:0] kind_sel;
		input [2:0] k;
		begin
			case (k)
				`TX_TPDO1: kind_sel = SEL_TPDO1;
				`TX_TPDO2: kind_sel = SEL_TPDO2;
				`TX_TPDO3: kind_sel = SEL_TPDO3;
				`TX_TPDO4: kind_sel = SEL_TPDO4;
				`TX_SDO:   kind_sel = SEL_SDOTX;
				`TX_EMCY:  kind_sel = SEL_EMCY;
				default:   kind_sel = SEL_GUARD;
			endcase
		end
	endfunction

	always @(posedge core_clk) begin
		if (!resetn) begin
			hb_pend_q <= 1'b0;
			tx_valid  <= 1'b0;
			tx_id     <= 11'h000;
			tx_len    <= 4'h0;
			tx_data   <= 64'h0;
		end else begin
			// A tick in the same cycle as the send keeps the request pending
			hb_pend_q <= hb_tick | (hb_pend_q & !hb_go);
			if (hb_go) begin
				tx_valid <= 1'b1;
				tx_id    <= eff_id(SEL_GUARD);
				tx_len   <= `HB_LEN;
				tx_data  <= {56'h0, node_state};
			end else if (app_tx_valid && app_tx_ready) begin
				tx_valid <= 1'b1;
				tx_id    <= eff_id(kind_sel(app_tx_kind));
				tx_len   <= app_tx_len;
				// Low word in bytes 0..3, each little-endian already in bit order
				tx_data  <= {app_tx_hi, app_tx_lo};
			end else if (tx_ready) begin
				tx_valid <= 1'b0;
			end
		end
	end

endmodule

// File: testbench/cobid_checker.sv
// Port-level checker for the identifier classifier
`timescale 1ns/1ns
module cobid_checker (
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic [6:0]  node_addr,
	input wire logic        rx_valid,
	input wire logic        rx_ext,
	input wire logic [10:0] rx_id,
	input wire logic        obj_valid,
	input wire logic [3:0]  obj_type,
	input wire logic        app_tx_valid,
	input wire logic        app_tx_ready,
	input wire logic [2:0]  app_tx_kind,
	input wire logic [31:0] app_tx_lo,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [10:0] tx_id,
	input wire logic [63:0] tx_data
);
	// All checks share one clock and one reset
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire std_rx = rx_valid && !rx_ext;
	wire taken = app_tx_valid && app_tx_ready && app_tx_kind == 3'h0;
	AST_NMT: assert property (std_rx && rx_id == 11'h000 |=> obj_valid && obj_type == 4'h1)
		else $error("nmt frame not classified");
	AST_SYNC: assert property (std_rx && rx_id == 11'h080 |=> obj_valid && obj_type == 4'h2)
		else $error("sync frame not classified");
	AST_EXT_DROP: assert property (rx_valid && rx_ext |=> !obj_valid)
		else $error("extended frame delivered");
	AST_OBJ_CAUSE: assert property (obj_valid |-> $past(rx_valid) && !$past(rx_ext))
		else $error("object without a standard frame");
	AST_OWN_RPDO1: assert property (std_rx && rx_id == {4'h4, node_addr} |=> obj_type == 4'h4)
		else $error("own receive object misclassified");
	AST_FOREIGN: assert property (std_rx && rx_id[10:7] == 4'h4 && rx_id[6:0] != node_addr
		|=> !obj_valid)
		else $error("foreign node frame delivered");
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_id)
		&& $stable(tx_data))
		else $error("frame changed while stalled");
	AST_TPDO1_ID: assert property (taken |=> tx_valid && tx_id == {4'h3, node_addr})
		else $error("first transmit object id wrong");
	AST_LSB_FIRST: assert property (taken |=> tx_data[31:0] == $past(app_tx_lo))
		else $error("low word not in first bytes");
	// Main scenarios reached
	cover property (obj_valid && obj_type == 4'h3);
	cover property (tx_valid && !tx_ready);
	cover property (rx_valid && rx_ext);
endmodule
bind canopen_cobid_classifier cobid_checker u_chk (.core_clk, .resetn, .node_addr, .rx_valid,
	.rx_ext, .rx_id, .obj_valid, .obj_type, .app_tx_valid, .app_tx_ready, .app_tx_kind,
	.app_tx_lo, .tx_valid, .tx_ready, .tx_id, .tx_data);

// File: testbench/dl_model.sv
// Data-link controller model that takes frames from the block
`timescale 1ns/1ns
module dl_model (
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic        slow,
	input wire logic        tx_valid,
	input wire logic [10:0] tx_id,
	input wire logic [63:0] tx_data,
	input wire logic [3:0]  tx_len,
	output logic            tx_ready,
	output logic [3:0]      got_len,
	output logic [10:0]     got_id,
	output logic [63:0]     got_data,
	output logic [7:0]      got_n
);
	logic [1:0] c_q;
	// Slow mode accepts one cycle in four, to stress frame holding
	always @(posedge core_clk) begin
		c_q <= c_q + 2'h1;
		tx_ready <= !slow || c_q == 2'h3;
		if (!resetn) begin
			c_q <= 2'h0;
			tx_ready <= 1'b0;
			got_n <= 8'h00;
		end else if (tx_valid && tx_ready) begin
			got_id <= tx_id;
			got_data <= tx_data;
			got_len <= tx_len;
			got_n <= got_n + 8'h01;
		end
	end
endmodule

// File: testbench/canopen_cobid_classifier_tb_top.sv
// Self-checking bench for the identifier classifier
`timescale 1ns/1ns
module canopen_cobid_classifier_tb_top;
	logic core_clk = 0, resetn = 0, cfg_wr = 0, hb_enable = 0, rx_valid = 0, rx_ext = 0;
	logic rx_rtr = 0, app_tx_valid = 0, slow = 0, obj_valid, obj_rtr, app_tx_ready, tx_valid;
	logic tx_ready;
	logic [6:0] node_addr = 7'h05, obj_node;
	logic [3:0] cfg_sel = 4'h0, rx_len = 4'h8, app_tx_len = 4'h8, obj_type, obj_len, tx_len;
	logic [3:0] got_len;
	logic [10:0] cfg_id = 11'h000, rx_id = 11'h000, tx_id, got_id;
	logic [7:0] node_state = 8'ha5, got_n;
	logic [63:0] rx_data = 64'h0, obj_data, tx_data, got_data;
	logic [2:0] app_tx_kind = 3'h0;
	logic [31:0] app_tx_lo = 32'h12345678, app_tx_hi = 32'h0000ff00;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	localparam logic [27:0] FCS = 28'he1b9753; // Function code per transmit kind
	localparam logic [14:0] ROWS [10] = '{{11'h000, 4'h1}, {11'h080, 4'h2}, {11'h085, 4'h3},
		{11'h205, 4'h4}, {11'h305, 4'h5}, {11'h405, 4'h6}, {11'h505, 4'h7}, {11'h605, 4'h8},
		{11'h705, 4'h9}, {11'h185, 4'h0}};
	canopen_cobid_classifier #(.HB_CYCLES(20)) dut (.core_clk, .resetn, .node_addr, .cfg_wr,
		.cfg_sel, .cfg_id, .hb_enable, .node_state, .rx_valid, .rx_ext, .rx_rtr, .rx_id,
		.rx_len, .rx_data, .obj_valid, .obj_type, .obj_node, .obj_rtr, .obj_len, .obj_data,
		.app_tx_valid, .app_tx_ready, .app_tx_kind, .app_tx_len, .app_tx_lo, .app_tx_hi,
		.tx_valid, .tx_ready, .tx_id, .tx_len, .tx_data);
	dl_model u_dl (.core_clk, .resetn, .slow, .tx_valid, .tx_id, .tx_data, .tx_len, .tx_ready,
		.got_len, .got_id, .got_data, .got_n);
	// Clock and hang guard
	always #10 core_clk = !core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task end_sim;
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [63:0] g, input logic [63:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// One received frame, result seen the cycle after it is taken
	task rx(input logic [10:0] id, input logic ext, input logic [3:0] et);
		@(posedge core_clk);
		rx_valid <= 1'b1;
		rx_id <= id;
		rx_ext <= ext;
		rx_data <= {53'h0, id};
		rx_rtr <= id[0];
		@(posedge core_clk);
		rx_valid <= 1'b0;
		#1 chk(obj_valid, et != 4'h0);
		if (et != 4'h0) begin
			chk(obj_type, et);
			chk(obj_node, id[6:0]);
			chk(obj_len, 4'h8);
			chk(obj_rtr, id[0]);
			chk(obj_data, {53'h0, id});
		end
	endtask
	// One transmit request, frame taken from the partner's record
	task tx(input logic [2:0] k, input logic [10:0] eid);
		logic [7:0] n0;
		n0 = got_n;
		@(posedge core_clk);
		app_tx_valid <= 1'b1;
		app_tx_kind <= k;
		// Ready moves only at edges, so its settled value holds for the next edge
		#1;
		while (app_tx_ready !== 1'b1) @(posedge core_clk) #1;
		@(posedge core_clk);
		app_tx_valid <= 1'b0;
		for (int i = 0; i < 20 && got_n == n0; i++) @(posedge core_clk) #1;
		chk(got_id, eid);
		chk(got_data, {app_tx_hi, app_tx_lo});
		chk(got_data[47:0], 48'hff0012345678);
		chk(got_len, 4'h8);
	endtask
	task cfg(input logic [3:0] s, input logic [10:0] id);
		@(posedge core_clk);
		cfg_wr <= 1'b1;
		cfg_sel <= s;
		cfg_id <= id;
		@(posedge core_clk);
		cfg_wr <= 1'b0;
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		#1 chk(obj_valid, 1'b0);
		for (int r = 0; r < 10; r++) rx(ROWS[r][14:4], 1'b0, ROWS[r][3:0]);
		rx(11'h205, 1'b1, 4'h0);
		rx(11'h206, 1'b0, 4'h0);
		rx(11'h0ff, 1'b0, 4'h3);
		$display("receive tests done");
		for (int k = 0; k < 7; k++) tx(k[2:0], {FCS[k*4+:4], 7'h05});
		slow <= 1'b1;
		tx(3'h0, 11'h185);
		cfg(4'h6, 11'h2a0);
		tx(3'h1, 11'h2a0);
		cfg(4'h0, 11'h7f0);
		rx(11'h7f0, 1'b0, 4'h4);
		$display("transmit tests done");
		hb_enable <= 1'b1;
		for (int i = 0; i < 200 && got_id != 11'h705; i++) @(posedge core_clk) #1;
		chk(got_id, 11'h705);
		chk(got_data, 64'ha5);
		chk(got_len, 4'h1);
		$display("heartbeat test done");
		// Mid-run reset must drop the pending frame and the overrides
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk) #1;
		chk(obj_valid, 1'b0);
		chk(tx_valid, 1'b0);
		chk(app_tx_ready, 1'b1);
		rx(11'h205, 1'b0, 4'h4);
		$display("reset test done");
		end_sim();
	end
endmodule
